// >>> bench/pll_clock_select_config_bench.sv
// self-checking bench for the power-up clock selection decode
`timescale 1ns/100ps
module pll_clock_select_config_bench;
	wire [3:0] C0_CLOCK_SELECT_IN, C1_CLOCK_SELECT_IN;
	wire [4:0] MEMORY_PLL_RATIO_IN, LANE_DIVIDER_B1_IN, LANE_DIV2_B1_OUT;
	wire [2:0] SERDES_B1_RATIO_IN, SERDES_B2_RATIO_IN, SERDES_B3_RATIO_IN;
	wire [1:0] MEMORY_PLL_RANGE_IN, S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
	wire [5:0] SERDES_B1_MULT_OUT, SERDES_B2_MULT_OUT, SERDES_B3_MULT_OUT;
	wire [7:0] MEMORY_RATIO_OUT;
	wire [31:0] S_AXI_RDATA_OUT;
	wire MEMORY_SYNC_MODE_IN, MEMORY_RATE_MODE_IN, MEMORY_RESERVED_BIT_IN, LANE_DIVIDER_B2_IN, LANE_DIVIDER_B3_IN;
	wire C0_SOURCE_SECOND_OUT, C0_DIVIDE_BY_TWO_OUT, C1_SOURCE_SECOND_OUT, C1_DIVIDE_BY_TWO_OUT, CONFIG_DONE_OUT;
	wire MEMORY_REF_PLATFORM_OUT, MEMORY_HIGH_RANGE_OUT, LANE_DIV2_B2_OUT, LANE_DIV2_B3_OUT, CONFIG_INVALID_OUT;
	wire S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT;
	logic CLK_IN = 0, RESET_N_IN = 0, bad = 0, done_d = 0, S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0;
	logic S_AXI_BREADY_IN = 0, S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 0;
	logic [7:0] S_AXI_AWADDR_IN = 0, S_AXI_ARADDR_IN = 0;
	logic [3:0] S_AXI_WSTRB_IN = 4'hf;
	logic [31:0] S_AXI_WDATA_IN = 0, pick = 32'h7abf036c, core_w;
	logic [63:0] q[$];
	int n_mismatch = 0, comparisons = 0;
	strap_source src (.pick_in(pick), .bad_in(bad), .*);
	pll_clock_select_config dut (.*);
	initial forever #4 CLK_IN = ~CLK_IN;
	function logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected {divide, source} of one complex
	function logic [1:0] cx(input logic [3:0] c, input logic one);
		case (c)
			4'h1: cx = one ? 2'b00 : 2'b10;
			4'h4: cx = 2'b01;
			4'h5: cx = one ? 2'b11 : 2'b00;
			default: cx = 2'b00;
		endcase
	endfunction
	function logic [5:0] sx(input logic [2:0] c, input int b);
		case (c)
			3'h1: sx = (b == 1) ? 6'h00 : 6'h14;
			3'h2: sx = 6'h19;
			3'h3: sx = 6'h28;
			3'h4: sx = 6'h32;
			3'h5: sx = (b == 3) ? 6'h18 : 6'h00;
			3'h6: sx = (b == 3) ? 6'h1e : 6'h00;
			default: sx = 6'h00;
		endcase
	endfunction
	task check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task rd(input logic [7:0] a, input logic [33:0] e);
		@(posedge CLK_IN);
		q.push_back({30'h0, e});
		S_AXI_ARADDR_IN <= a;
		S_AXI_ARVALID_IN <= 1;
		S_AXI_RREADY_IN <= 1;
		do @(posedge CLK_IN); while (!S_AXI_ARREADY_OUT);
		S_AXI_ARVALID_IN <= 0;
		do @(posedge CLK_IN); while (!S_AXI_RVALID_OUT);
		S_AXI_RREADY_IN <= 0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aw, w;
		@(posedge CLK_IN);
		aw = 0;
		w = 0;
		q.push_back({62'h0, e});
		S_AXI_AWADDR_IN <= a;
		S_AXI_WDATA_IN <= d;
		S_AXI_AWVALID_IN <= 1;
		S_AXI_WVALID_IN <= 1;
		S_AXI_BREADY_IN <= 1;
		while (!(aw && w)) begin
			@(posedge CLK_IN);
			if (!aw && S_AXI_AWREADY_OUT) begin aw = 1; S_AXI_AWVALID_IN <= 0; end
			if (!w && S_AXI_WREADY_OUT) begin w = 1; S_AXI_WVALID_IN <= 0; end
		end
		do @(posedge CLK_IN); while (!S_AXI_BVALID_OUT);
		S_AXI_BREADY_IN <= 0;
	endtask
	// watches outputs and takes the oldest note for each result
	always @(posedge CLK_IN) begin
		done_d <= CONFIG_DONE_OUT;
		if (CONFIG_DONE_OUT && !done_d)
			check({25'h0, C0_DIVIDE_BY_TWO_OUT, C0_SOURCE_SECOND_OUT, C1_DIVIDE_BY_TWO_OUT, C1_SOURCE_SECOND_OUT,
				MEMORY_REF_PLATFORM_OUT, MEMORY_RATIO_OUT, MEMORY_HIGH_RANGE_OUT, SERDES_B1_MULT_OUT, SERDES_B2_MULT_OUT,
				SERDES_B3_MULT_OUT, LANE_DIV2_B1_OUT, LANE_DIV2_B2_OUT, LANE_DIV2_B3_OUT}, q.pop_front());
		if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
			check({30'h0, S_AXI_RRESP_OUT, S_AXI_RDATA_OUT}, q.pop_front());
		if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
			check({62'h0, S_AXI_BRESP_OUT}, q.pop_front());
	end
	initial begin
		#100000;
		n_mismatch++;
		complete_run;
	end
	initial begin
		for (int i = 0; i < 6; i++) begin
			RESET_N_IN <= 0;
			bad <= (i % 3 == 2);
			pick <= lfsr_next(pick);
			repeat (8) @(posedge CLK_IN);
			q.push_back({25'h0, cx(C0_CLOCK_SELECT_IN, 0), cx(C1_CLOCK_SELECT_IN, 1), MEMORY_SYNC_MODE_IN, 3'h0,
				MEMORY_PLL_RATIO_IN, MEMORY_PLL_RANGE_IN[0], sx(SERDES_B1_RATIO_IN, 1), sx(SERDES_B2_RATIO_IN, 2),
				sx(SERDES_B3_RATIO_IN, 3), LANE_DIVIDER_B1_IN, LANE_DIVIDER_B2_IN, LANE_DIVIDER_B3_IN});
			core_w = {22'h0, bad, 1'b1, 2'h0, cx(C1_CLOCK_SELECT_IN, 1), 1'b0, bad, cx(C0_CLOCK_SELECT_IN, 0)};
			RESET_N_IN <= 1;
			while (!CONFIG_DONE_OUT) @(posedge CLK_IN);
			repeat (2) @(posedge CLK_IN);
			check(CONFIG_INVALID_OUT, bad);
			rd(8'h00, {2'h0, core_w});
			rd(8'h04, {13'h0, MEMORY_PLL_RATIO_IN, 6'h0, MEMORY_PLL_RANGE_IN[0], MEMORY_SYNC_MODE_IN, 3'h0,
				MEMORY_PLL_RATIO_IN});
			rd(8'h20, {2'h2, 32'h0});
			wr(8'h20, 32'h1, 2'h2);
			wr(8'h00, 32'h0, 2'h0);
			if (bad) begin
				wr(8'h10, 32'h1, 2'h0);
				repeat (2) @(posedge CLK_IN);
				check(CONFIG_INVALID_OUT, 0);
			end
			pick <= lfsr_next(pick);
			repeat (4) @(posedge CLK_IN);
			rd(8'h00, {2'h0, core_w});
		end
		complete_run;
	end
endmodule // pll_clock_select_config_bench

// >>> bench/pll_select_asserts.sv
// checker for the power-up clock selection decode
`timescale 1ns/100ps
module pll_select_checker (
	input wire logic       CLK_IN, RESET_N_IN, MEMORY_SYNC_MODE_IN, MEMORY_REF_PLATFORM_OUT,
	input wire logic       C0_SOURCE_SECOND_OUT, C0_DIVIDE_BY_TWO_OUT, CONFIG_DONE_OUT, CONFIG_INVALID_OUT,
	input wire logic [3:0] C0_CLOCK_SELECT_IN,
	input wire logic [4:0] LANE_DIVIDER_B1_IN, LANE_DIV2_B1_OUT,
	input wire logic [7:0] MEMORY_RATIO_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	sequence released; $rose(RESET_N_IN); endsequence
	sequence captured; $rose(CONFIG_DONE_OUT); endsequence
	a_done_timing: assert property (released |-> !CONFIG_DONE_OUT [*4] ##1 CONFIG_DONE_OUT)
		else $error("capture edge wrong");
	a_done_sticky: assert property (CONFIG_DONE_OUT |=> CONFIG_DONE_OUT)
		else $error("done dropped");
	a_choice_held: assert property (CONFIG_DONE_OUT |=> $stable({C0_SOURCE_SECOND_OUT, C0_DIVIDE_BY_TWO_OUT,
		MEMORY_RATIO_OUT, LANE_DIV2_B1_OUT}))
		else $error("choice moved");
	a_core_decode: assert property (captured |-> {C0_SOURCE_SECOND_OUT, C0_DIVIDE_BY_TWO_OUT} ==
		((C0_CLOCK_SELECT_IN == 4'h4) ? 2'b10 : (C0_CLOCK_SELECT_IN == 4'h1) ? 2'b01 : 2'b00))
		else $error("core decode");
	a_memory_ref: assert property (captured and MEMORY_RATIO_OUT != 8'h0 |->
		MEMORY_REF_PLATFORM_OUT == MEMORY_SYNC_MODE_IN) else $error("memory reference");
	a_sync_ratio: assert property (captured and MEMORY_REF_PLATFORM_OUT |-> MEMORY_RATIO_OUT == 8'h01)
		else $error("sync ratio");
	a_lane_pairs: assert property (captured |-> LANE_DIV2_B1_OUT == LANE_DIVIDER_B1_IN)
		else $error("lane pairs");
	a_invalid_flag: assert property (captured and C0_CLOCK_SELECT_IN == 4'h5 |=> CONFIG_INVALID_OUT)
		else $error("invalid flag");
endmodule // pll_select_checker
bind pll_clock_select_config pll_select_checker chk (.*);

// >>> bench/strap_source.sv
// configuration word source: legal strap fields from a random pick, except a reserved complex 0 code when bad_in is set
`timescale 1ns/100ps
module strap_source (
	input  wire logic [31:0] pick_in,
	input  wire logic        bad_in,
	output logic [3:0] C0_CLOCK_SELECT_IN, C1_CLOCK_SELECT_IN,
	output logic [4:0] MEMORY_PLL_RATIO_IN, LANE_DIVIDER_B1_IN,
	output logic [2:0] SERDES_B1_RATIO_IN, SERDES_B2_RATIO_IN, SERDES_B3_RATIO_IN,
	output logic [1:0] MEMORY_PLL_RANGE_IN,
	output logic MEMORY_SYNC_MODE_IN, MEMORY_RATE_MODE_IN, MEMORY_RESERVED_BIT_IN, LANE_DIVIDER_B2_IN, LANE_DIVIDER_B3_IN
);
	localparam logic [39:0] ASYNC_CODES = {5'h0d, 5'h0d, 5'h0c, 5'h0a, 5'h09, 5'h08, 5'h06, 5'h05};
	always_comb begin
		// bad_in asks for a reserved select code on complex 0
		// a PLL borrowed by the other complex is taken to run at the slower, derated rate
		C0_CLOCK_SELECT_IN = bad_in ? 4'h5 : {1'b0, pick_in[1], 1'b0, pick_in[0] & ~pick_in[1]};
		C1_CLOCK_SELECT_IN = {1'b0, |pick_in[3:2], 1'b0, &pick_in[3:2]};
		// platform clock is taken to meet the PCI Express and RapidIO minimums
		MEMORY_SYNC_MODE_IN = pick_in[4];
		MEMORY_RATE_MODE_IN = pick_in[4];
		MEMORY_RESERVED_BIT_IN = 1'b0;
		MEMORY_PLL_RATIO_IN = pick_in[4] ? 5'h01 : ASYNC_CODES[pick_in[7:5] * 5 +: 5];
		// pick bit 8 stands for a reference clock above the ratio's cutoff
		MEMORY_PLL_RANGE_IN = {1'b0, pick_in[8]};
		SERDES_B1_RATIO_IN = (pick_in[10:9] == 2'h3) ? 3'h2 : 3'h2 + pick_in[10:9];
		SERDES_B2_RATIO_IN = 3'h1 + pick_in[12:11];
		SERDES_B3_RATIO_IN = (pick_in[15:13] > 3'h5) ? 3'h1 : pick_in[15:13] + 3'h1;
		LANE_DIVIDER_B1_IN = pick_in[20:16];
		LANE_DIVIDER_B2_IN = pick_in[21];
		LANE_DIVIDER_B3_IN = pick_in[22];
	end
endmodule // strap_source

// >>> logic/pll_clock_select_config.v
// power-up clock selection decode with an AXI4-Lite status port
// Behaviour
// (RULE_01) each core complex picks its own clock
// (RULE_02) select codes map to PLL and divider
// (RULE_03) second PLL on complex 0 runs slower
// (RULE_04) first PLL on complex 1 runs slower
// (RULE_05) one setting clocks both memory controllers
// (RULE_06) memory reference: system async, platform sync
// (RULE_07) async memory ratio codes five to thirteen
// (RULE_08) range bits set by reference cutoff
// (RULE_09) cutoff frequency depends on chosen ratio
// (RULE_10) sync mode only supports one-to-one code
// (RULE_11) sync and rate bits match the mode
// (RULE_12) memory reserved bit held at zero
// (RULE_13) platform clock meets PCI Express minimum
// (RULE_14) platform clock meets RapidIO minimum
// (RULE_15) serdes bank ratio codes per bank
// (RULE_16) bank 1 divider bit per lane pair
// (RULE_17) banks 2, 3 one divider bit
// (RULE_18) fields sampled once at power-up
// (RULE_19) selections held; reserved codes flag invalid
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "pll_clock_select_consts.vh"
module pll_clock_select_config #(
	parameter ADDR_WIDTH = 8
) (
	// clock and reset
	input  wire                  CLK_IN,
	input  wire                  RESET_N_IN,
	// configuration word fields
	input  wire [3:0]            C0_CLOCK_SELECT_IN,
	input  wire [3:0]            C1_CLOCK_SELECT_IN,
	input  wire [4:0]            MEMORY_PLL_RATIO_IN,
	input  wire [1:0]            MEMORY_PLL_RANGE_IN,
	input  wire                  MEMORY_SYNC_MODE_IN,
	input  wire                  MEMORY_RATE_MODE_IN,
	input  wire                  MEMORY_RESERVED_BIT_IN,
	input  wire [2:0]            SERDES_B1_RATIO_IN,
	input  wire [2:0]            SERDES_B2_RATIO_IN,
	input  wire [2:0]            SERDES_B3_RATIO_IN,
	input  wire [4:0]            LANE_DIVIDER_B1_IN,
	input  wire                  LANE_DIVIDER_B2_IN,
	input  wire                  LANE_DIVIDER_B3_IN,
	// decoded clock choices, capture done and invalid flags
	output wire                  C0_SOURCE_SECOND_OUT,
	output wire                  C0_DIVIDE_BY_TWO_OUT,
	output wire                  C1_SOURCE_SECOND_OUT,
	output wire                  C1_DIVIDE_BY_TWO_OUT,
	output wire                  MEMORY_REF_PLATFORM_OUT,
	output wire [7:0]            MEMORY_RATIO_OUT,
	output wire                  MEMORY_HIGH_RANGE_OUT,
	output wire [5:0]            SERDES_B1_MULT_OUT,
	output wire [5:0]            SERDES_B2_MULT_OUT,
	output wire [5:0]            SERDES_B3_MULT_OUT,
	output wire [4:0]            LANE_DIV2_B1_OUT,
	output wire                  LANE_DIV2_B2_OUT,
	output wire                  LANE_DIV2_B3_OUT,
	output wire                  CONFIG_DONE_OUT,
	output wire                  CONFIG_INVALID_OUT,
	// AXI4-Lite write channels
	input  wire [ADDR_WIDTH-1:0] S_AXI_AWADDR_IN,
	input  wire                  S_AXI_AWVALID_IN,
	output wire                  S_AXI_AWREADY_OUT,
	input  wire [31:0]           S_AXI_WDATA_IN,
	input  wire [3:0]            S_AXI_WSTRB_IN,
	input  wire                  S_AXI_WVALID_IN,
	output wire                  S_AXI_WREADY_OUT,
	output wire [1:0]            S_AXI_BRESP_OUT,
	output wire                  S_AXI_BVALID_OUT,
	input  wire                  S_AXI_BREADY_IN,
	// AXI4-Lite read channels
	input  wire [ADDR_WIDTH-1:0] S_AXI_ARADDR_IN,
	input  wire                  S_AXI_ARVALID_IN,
	output wire                  S_AXI_ARREADY_OUT,
	output wire [31:0]           S_AXI_RDATA_OUT,
	output wire [1:0]            S_AXI_RRESP_OUT,
	output wire                  S_AXI_RVALID_OUT,
	input  wire                  S_AXI_RREADY_IN
);
	// ********************
	// strap synchronisation
	// ********************
	wire [33:0] strap_raw;
	wire [33:0] strap_sync;
	assign strap_raw = {C0_CLOCK_SELECT_IN, C1_CLOCK_SELECT_IN, MEMORY_PLL_RATIO_IN, MEMORY_PLL_RANGE_IN,
		MEMORY_SYNC_MODE_IN, MEMORY_RATE_MODE_IN, MEMORY_RESERVED_BIT_IN, SERDES_B1_RATIO_IN,
		SERDES_B2_RATIO_IN, SERDES_B3_RATIO_IN, LANE_DIVIDER_B1_IN, LANE_DIVIDER_B2_IN, LANE_DIVIDER_B3_IN};

	sync_two_flop #(.WIDTH(34)) u_strap_sync (
		.clk_in     (CLK_IN),
		.reset_n_in (RESET_N_IN),
		.async_in   (strap_raw),
		.sync_out   (strap_sync)
	);

	wire [3:0] c0_code      = strap_sync[33:30];
	wire [3:0] c1_code      = strap_sync[29:26];
	wire [4:0] memory_code  = strap_sync[25:21];
	wire [1:0] memory_range = strap_sync[20:19];
	wire       sync_mode    = strap_sync[18];
	wire       rate_mode    = strap_sync[17];
	wire       reserved_bit = strap_sync[16];
	wire [2:0] b1_code      = strap_sync[15:13];
	wire [2:0] b2_code      = strap_sync[12:10];
	wire [2:0] b3_code      = strap_sync[9:7];
	wire [6:0] lane_bits    = strap_sync[6:0];

	// ********************
	// core complex decode: {invalid, second pll, divide by two}
	// ********************
	function [2:0] core_decode;
		input [3:0] code;
		input       complex_one;
		begin
			case (code) // [RULE_01] [RULE_02]
			`CORE_SEL_FIRST_DIV1:  core_decode = 3'h0;
			`CORE_SEL_FIRST_DIV2:  core_decode = complex_one ? 3'h4 : 3'h1;
			`CORE_SEL_SECOND_DIV1: core_decode = 3'h2;
			`CORE_SEL_SECOND_DIV2: core_decode = complex_one ? 3'h3 : 3'h4;
			default:               core_decode = 3'h4; // [RULE_19]
			endcase
		end
	endfunction

	wire [2:0] c0_dec = core_decode(c0_code, 1'b0);
	wire [2:0] c1_dec = core_decode(c1_code, 1'b1);

	// ********************
	// memory PLL decode
	// ********************
	reg [7:0] memory_mult;
	reg       memory_code_bad;
	always @* begin
		memory_mult     = 8'h00;
		memory_code_bad = 1'b0;
		if (sync_mode) begin
			if (memory_code == `MEMORY_CODE_SYNC_1) begin // [RULE_10]
				memory_mult = `MEMORY_MULT_1;
			end else begin
				memory_code_bad = 1'b1;
			end
		end else begin
			case (memory_code) // [RULE_07]
			`MEMORY_CODE_5:  memory_mult = `MEMORY_MULT_5;
			`MEMORY_CODE_6:  memory_mult = `MEMORY_MULT_6;
			`MEMORY_CODE_8:  memory_mult = `MEMORY_MULT_8;
			`MEMORY_CODE_9:  memory_mult = `MEMORY_MULT_9;
			`MEMORY_CODE_10: memory_mult = `MEMORY_MULT_10;
			`MEMORY_CODE_12: memory_mult = `MEMORY_MULT_12;
			`MEMORY_CODE_13: memory_mult = `MEMORY_MULT_13;
			default:         memory_code_bad = 1'b1;
			endcase
		end
	end

	// mode bits that disagree, a set reserved bit or an unused range code are all bad straps
	wire memory_bad = memory_code_bad | (sync_mode != rate_mode) | reserved_bit | // [RULE_11] [RULE_12]
		(memory_range != `MEMORY_RANGE_LOW && memory_range != `MEMORY_RANGE_HIGH); // [RULE_08]

	// ********************
	// serdes bank decode
	// ********************
	wire [5:0] b1_mult;
	wire [5:0] b2_mult;
	wire [5:0] b3_mult;
	wire       b1_bad;
	wire       b2_bad;
	wire       b3_bad;

	serdes_bank_decode #(.BANK(1)) u_bank1 (
		.ratio_code_in  (b1_code),
		.multiplier_out (b1_mult),
		.invalid_out    (b1_bad)
	);
	serdes_bank_decode #(.BANK(2)) u_bank2 (
		.ratio_code_in  (b2_code),
		.multiplier_out (b2_mult),
		.invalid_out    (b2_bad)
	);
	serdes_bank_decode #(.BANK(3)) u_bank3 (
		.ratio_code_in  (b3_code),
		.multiplier_out (b3_mult),
		.invalid_out    (b3_bad)
	);

	// ********************
	// one-time capture after reset release
	// ********************
	reg [1:0] wait_count_r;
	reg       done_r;
	reg [2:0] c0_r;
	reg [2:0] c1_r;
	reg [7:0] memory_mult_r;
	reg [4:0] memory_code_r;
	reg       memory_ref_r;
	reg       memory_range_r;
	reg       memory_bad_r;
	reg [5:0] b1_mult_r;
	reg [5:0] b2_mult_r;
	reg [5:0] b3_mult_r;
	reg [2:0] bank_bad_r;
	reg [6:0] lane_r;
	reg       invalid_out_r;
	reg       mask_r;

	wire capture    = !done_r && (wait_count_r == `CAPTURE_DELAY_CYCLES);
	wire any_bad    = c0_r[2] | c1_r[2] | memory_bad_r | (|bank_bad_r);

	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			wait_count_r   <= 2'h0;
			done_r         <= 1'b0;
			c0_r           <= 3'h0;
			c1_r           <= 3'h0;
			memory_mult_r  <= 8'h00;
			memory_code_r  <= 5'h00;
			memory_ref_r   <= 1'b0;
			memory_range_r <= 1'b0;
			memory_bad_r   <= 1'b0;
			b1_mult_r      <= 6'h00;
			b2_mult_r      <= 6'h00;
			b3_mult_r      <= 6'h00;
			bank_bad_r     <= 3'h0;
			lane_r         <= 7'h00;
			invalid_out_r  <= 1'b0;
		end else begin
			if (!done_r && !capture) begin
				wait_count_r <= wait_count_r + 2'h1;
			end
			// decoded values load once and never move again
			if (capture) begin // [RULE_18] [RULE_19]
				done_r         <= 1'b1;
				c0_r           <= c0_dec;
				c1_r           <= c1_dec;
				memory_mult_r  <= memory_mult; // [RULE_05]
				memory_code_r  <= memory_code;
				memory_ref_r   <= sync_mode; // [RULE_06]
				memory_range_r <= memory_range[0];
				memory_bad_r   <= memory_bad;
				b1_mult_r      <= b1_mult;
				b2_mult_r      <= b2_mult;
				b3_mult_r      <= b3_mult;
				bank_bad_r     <= {b3_bad, b2_bad, b1_bad};
				lane_r         <= lane_bits; // [RULE_16] [RULE_17]
			end
			invalid_out_r <= done_r & any_bad & ~mask_r; // [RULE_19]
		end
	end

	// ********************
	// AXI4-Lite write side
	// ********************
	reg                  awready_r;
	reg                  wready_r;
	reg                  aw_held_r;
	reg                  w_held_r;
	reg [ADDR_WIDTH-1:0] awaddr_r;
	reg [31:0]           wdata_r;
	reg                  wstrb0_r;
	reg                  bvalid_r;
	reg [1:0]            bresp_r;

	wire [7:0] wr_offset = {awaddr_r[7:2], 2'h0};
	wire       wr_known  = (wr_offset == `CORE_STATUS_OFFSET) || (wr_offset == `MEMORY_STATUS_OFFSET) ||
		(wr_offset == `SERDES_STATUS_OFFSET) || (wr_offset == `LANE_DIVIDER_STATUS_OFFSET) ||
		(wr_offset == `CLOCK_CONTROL_OFFSET);

	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= {ADDR_WIDTH{1'b0}};
			wdata_r   <= 32'h00000000;
			wstrb0_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `AXI_RESP_OKAY;
			mask_r    <= `CONTROL_RESET;
		end else begin
			if (awready_r && S_AXI_AWVALID_IN) begin
				awready_r <= 1'b0;
				aw_held_r <= 1'b1;
				awaddr_r  <= S_AXI_AWADDR_IN;
			end else if (!aw_held_r && !bvalid_r) begin
				awready_r <= 1'b1;
			end
			if (wready_r && S_AXI_WVALID_IN) begin
				wready_r <= 1'b0;
				w_held_r <= 1'b1;
				wdata_r  <= S_AXI_WDATA_IN;
				wstrb0_r <= S_AXI_WSTRB_IN[0];
			end else if (!w_held_r && !bvalid_r) begin
				wready_r <= 1'b1;
			end
			if (aw_held_r && w_held_r && !bvalid_r) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_known ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
				if (wr_offset == `CLOCK_CONTROL_OFFSET && wstrb0_r) begin
					mask_r <= wdata_r[`CONTROL_MASK_BIT];
				end
			end else if (bvalid_r && S_AXI_BREADY_IN) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ********************
	// AXI4-Lite read side
	// ********************
	reg        arready_r;
	reg        rvalid_r;
	reg [31:0] rdata_r;
	reg [1:0]  rresp_r;
	reg [31:0] rd_word;
	reg        rd_known;

	wire [7:0] rd_offset = {S_AXI_ARADDR_IN[7:2], 2'h0};

	always @* begin
		rd_word  = 32'h00000000;
		rd_known = 1'b1;
		case (rd_offset)
		`CORE_STATUS_OFFSET: begin
			rd_word[`CORE_C0_SOURCE_BIT]   = c0_r[1];
			rd_word[`CORE_C0_DIVIDE_BIT]   = c0_r[0];
			rd_word[`CORE_C0_INVALID_BIT]  = c0_r[2];
			rd_word[`CORE_C1_SOURCE_BIT]   = c1_r[1];
			rd_word[`CORE_C1_DIVIDE_BIT]   = c1_r[0];
			rd_word[`CORE_C1_INVALID_BIT]  = c1_r[2];
			rd_word[`CORE_DONE_BIT]        = done_r;
			rd_word[`CORE_ANY_INVALID_BIT] = done_r & any_bad;
		end
		`MEMORY_STATUS_OFFSET: begin
			rd_word[`MEMORY_RATIO_LSB+7:`MEMORY_RATIO_LSB] = memory_mult_r;
			rd_word[`MEMORY_REF_BIT]                       = memory_ref_r;
			rd_word[`MEMORY_RANGE_BIT]                     = memory_range_r;
			rd_word[`MEMORY_INVALID_BIT]                   = memory_bad_r;
			rd_word[`MEMORY_CODE_LSB+4:`MEMORY_CODE_LSB]   = memory_code_r;
		end
		`SERDES_STATUS_OFFSET: begin
			rd_word[`SERDES_B1_RATIO_LSB+5:`SERDES_B1_RATIO_LSB] = b1_mult_r;
			rd_word[`SERDES_B2_RATIO_LSB+5:`SERDES_B2_RATIO_LSB] = b2_mult_r;
			rd_word[`SERDES_B3_RATIO_LSB+5:`SERDES_B3_RATIO_LSB] = b3_mult_r;
			rd_word[`SERDES_B1_INVALID_BIT]                      = bank_bad_r[0];
			rd_word[`SERDES_B2_INVALID_BIT]                      = bank_bad_r[1];
			rd_word[`SERDES_B3_INVALID_BIT]                      = bank_bad_r[2];
		end
		`LANE_DIVIDER_STATUS_OFFSET: begin
			rd_word[`LANE_B1_LSB+4:`LANE_B1_LSB] = lane_r[6:2];
			rd_word[`LANE_B2_BIT]                = lane_r[1];
			rd_word[`LANE_B3_BIT]                = lane_r[0];
		end
		`CLOCK_CONTROL_OFFSET: rd_word[`CONTROL_MASK_BIT] = mask_r;
		default: rd_known = 1'b0;
		endcase
	end

	always @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h00000000;
			rresp_r   <= `AXI_RESP_OKAY;
		end else begin
			if (arready_r && S_AXI_ARVALID_IN) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= rd_word;
				rresp_r   <= rd_known ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
			end else if (rvalid_r && S_AXI_RREADY_IN) begin
				rvalid_r <= 1'b0;
			end else if (!rvalid_r) begin
				arready_r <= 1'b1;
			end
		end
	end

	// ********************
	// outputs
	// ********************
	assign C0_SOURCE_SECOND_OUT    = c0_r[1];
	assign C0_DIVIDE_BY_TWO_OUT    = c0_r[0];
	assign C1_SOURCE_SECOND_OUT    = c1_r[1];
	assign C1_DIVIDE_BY_TWO_OUT    = c1_r[0];
	assign MEMORY_REF_PLATFORM_OUT = memory_ref_r;
	assign MEMORY_RATIO_OUT        = memory_mult_r;
	assign MEMORY_HIGH_RANGE_OUT   = memory_range_r;
	assign SERDES_B1_MULT_OUT      = b1_mult_r;
	assign SERDES_B2_MULT_OUT      = b2_mult_r;
	assign SERDES_B3_MULT_OUT      = b3_mult_r;
	assign LANE_DIV2_B1_OUT        = lane_r[6:2];
	assign LANE_DIV2_B2_OUT        = lane_r[1];
	assign LANE_DIV2_B3_OUT        = lane_r[0];
	assign CONFIG_DONE_OUT         = done_r;
	assign CONFIG_INVALID_OUT      = invalid_out_r;
	assign S_AXI_AWREADY_OUT       = awready_r;
	assign S_AXI_WREADY_OUT        = wready_r;
	assign S_AXI_BRESP_OUT         = bresp_r;
	assign S_AXI_BVALID_OUT        = bvalid_r;
	assign S_AXI_ARREADY_OUT       = arready_r;
	assign S_AXI_RDATA_OUT         = rdata_r;
	assign S_AXI_RRESP_OUT         = rresp_r;
	assign S_AXI_RVALID_OUT        = rvalid_r;
endmodule // pll_clock_select_config

// >>> logic/serdes_bank_decode.v
// serdes PLL ratio decode for one bank
`timescale 1ns/100ps
`include "pll_clock_select_consts.vh"
module serdes_bank_decode #(
	parameter BANK = 1
) (
	// ratio code in
	input  wire [2:0] ratio_code_in,
	// decoded multiplier and invalid flag out
	output reg  [5:0] multiplier_out,
	output reg        invalid_out
);
	always @* begin
		multiplier_out = 6'h00;
		invalid_out    = 1'b0;
		case (ratio_code_in) // [RULE_15]
		`SERDES_CODE_20: begin
			if (BANK == 1) begin
				invalid_out = 1'b1; // [RULE_19]
			end else begin
				multiplier_out = `SERDES_MULT_20;
			end
		end
		`SERDES_CODE_25: multiplier_out = `SERDES_MULT_25;
		`SERDES_CODE_40: multiplier_out = `SERDES_MULT_40;
		`SERDES_CODE_50: multiplier_out = `SERDES_MULT_50;
		`SERDES_CODE_24: begin
			if (BANK == 3) begin
				multiplier_out = `SERDES_MULT_24;
			end else begin
				invalid_out = 1'b1;
			end
		end
		`SERDES_CODE_30: begin
			if (BANK == 3) begin
				multiplier_out = `SERDES_MULT_30;
			end else begin
				invalid_out = 1'b1;
			end
		end
		default: invalid_out = 1'b1; // [RULE_19]
		endcase
	end
endmodule // serdes_bank_decode

// >>> logic/sync_two_flop.v
// two flip-flop synchroniser for a bus of strap levels
`timescale 1ns/100ps
module sync_two_flop #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clk_in,
	input  wire             reset_n_in,
	// levels
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] first_r;
	reg [WIDTH-1:0] second_r;

	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			first_r  <= {WIDTH{1'b0}};
			second_r <= {WIDTH{1'b0}};
		end else begin
			first_r  <= async_in;
			second_r <= first_r;
		end
	end

	assign sync_out = second_r;
endmodule // sync_two_flop

// >>> shared/pll_clock_select_consts.vh
// constants for the power-up clock selection decode block
`ifndef PLL_CLOCK_SELECT_CONSTS_VH
`define PLL_CLOCK_SELECT_CONSTS_VH

// ********************
// register byte offsets
// ********************
`define CORE_STATUS_OFFSET         8'h00
`define MEMORY_STATUS_OFFSET       8'h04
`define SERDES_STATUS_OFFSET       8'h08
`define LANE_DIVIDER_STATUS_OFFSET 8'h0c
`define CLOCK_CONTROL_OFFSET       8'h10

// ********************
// core_status fields
// ********************
`define CORE_C0_SOURCE_BIT   0
`define CORE_C0_DIVIDE_BIT   1
`define CORE_C0_INVALID_BIT  2
`define CORE_C1_SOURCE_BIT   4
`define CORE_C1_DIVIDE_BIT   5
`define CORE_C1_INVALID_BIT  6
`define CORE_DONE_BIT        8
`define CORE_ANY_INVALID_BIT 9

// ********************
// memory_status fields
// ********************
`define MEMORY_RATIO_LSB      0
`define MEMORY_REF_BIT        8
`define MEMORY_RANGE_BIT      9
`define MEMORY_INVALID_BIT    10
`define MEMORY_CODE_LSB       16

// ********************
// serdes_status and lane_divider_status fields
// ********************
`define SERDES_B1_RATIO_LSB   0
`define SERDES_B2_RATIO_LSB   8
`define SERDES_B3_RATIO_LSB   16
`define SERDES_B1_INVALID_BIT 24
`define SERDES_B2_INVALID_BIT 25
`define SERDES_B3_INVALID_BIT 26
`define LANE_B1_LSB           0
`define LANE_B2_BIT           5
`define LANE_B3_BIT           6

// ********************
// clock_control fields and reset value
// ********************
`define CONTROL_MASK_BIT      0
`define CONTROL_RESET         1'h0

// ********************
// core complex source-select codes
// ********************
`define CORE_SEL_FIRST_DIV1   4'h0
`define CORE_SEL_FIRST_DIV2   4'h1
`define CORE_SEL_SECOND_DIV1  4'h4
`define CORE_SEL_SECOND_DIV2  4'h5

// ********************
// memory PLL ratio codes and multipliers
// ********************
`define MEMORY_CODE_SYNC_1    5'h01
`define MEMORY_CODE_5         5'h05
`define MEMORY_CODE_6         5'h06
`define MEMORY_CODE_8         5'h08
`define MEMORY_CODE_9         5'h09
`define MEMORY_CODE_10        5'h0a
`define MEMORY_CODE_12        5'h0c
`define MEMORY_CODE_13        5'h0d
`define MEMORY_MULT_1         8'h01
`define MEMORY_MULT_5         8'h05
`define MEMORY_MULT_6         8'h06
`define MEMORY_MULT_8         8'h08
`define MEMORY_MULT_9         8'h09
`define MEMORY_MULT_10        8'h0a
`define MEMORY_MULT_12        8'h0c
`define MEMORY_MULT_13        8'h0d
`define MEMORY_RANGE_LOW      2'h0
`define MEMORY_RANGE_HIGH     2'h1

// ********************
// serdes PLL ratio codes and multipliers
// ********************
`define SERDES_CODE_20        3'h1
`define SERDES_CODE_25        3'h2
`define SERDES_CODE_40        3'h3
`define SERDES_CODE_50        3'h4
`define SERDES_CODE_24        3'h5
`define SERDES_CODE_30        3'h6
`define SERDES_MULT_20        6'h14
`define SERDES_MULT_25        6'h19
`define SERDES_MULT_40        6'h28
`define SERDES_MULT_50        6'h32
`define SERDES_MULT_24        6'h18
`define SERDES_MULT_30        6'h1e

// ********************
// timing and bus answers
// ********************
`define CAPTURE_DELAY_CYCLES  2'h3
`define AXI_RESP_OKAY         2'h0
`define AXI_RESP_SLVERR       2'h2

`endif
